// ==== include/host_pins_pkg.sv ====
// constants for the host port pin function block
`default_nettype none
package host_pins_pkg;
  // port control word layout (16 bits)
  localparam int CTRL_W        = 16;
  localparam int BIT_HOST_EN   = 0;   // 1: host function, 0: general-purpose io
  localparam int BIT_DBL_STRB  = 1;   // 1: separate read / write strobes
  localparam int BIT_MUXED     = 2;   // 1: multiplexed address/data bus
  localparam int BIT_DBL_REQ   = 3;   // 1: separate tx / rx requests
  localparam int BIT_REQ_OD    = 4;   // 1: requests are open-drain
  localparam int BIT_STRB_POL  = 5;   // 1: strobes active high
  localparam int BIT_CS_POL    = 6;   // 1: chip select active high
  localparam int BIT_REQ_POL   = 7;   // 1: requests active high
  localparam int BIT_ACK_POL   = 8;   // 1: acknowledge active high
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // general-purpose io pins handled here: 11..15
  localparam int NPINS   = 5;
  localparam int PIN_LO  = 11;
  localparam logic [4:0] DIR_RESET = 5'h00;
endpackage : host_pins_pkg
`default_nettype wire

// ==== hw/pin_cell.sv ====
// one port pin: input synchroniser plus registered output drive
`default_nettype none
module pin_cell (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic pad_in,
  input  wire logic hold,
  input  wire logic next_out,
  input  wire logic next_oe_n,
  output logic      pin_sync,
  output logic      pad_out,
  output logic      pad_oe_n
);
  logic meta;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta     <= pad_in;
      pin_sync <= meta;
    end
  end

  // reset: every pin an undriven input
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pad_out  <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (!hold) begin
      pad_out  <= next_out;
      pad_oe_n <= next_oe_n;
    end
  end
endmodule : pin_cell
`default_nettype wire

// ==== hw/host_port_pins.sv ====
// pin function steering for host port pins 11 to 15
//
// Function
// - single strobe, host mode: pin eleven is the read/write select input.
// - double strobe: pin eleven is the read strobe input.
// - single strobe: pin twelve is the one data strobe for reads and writes.
// - double strobe: pin twelve is the write strobe input.
// - non-multiplexed: accept access only while chip select asserted; default active low.
// - multiplexed: pin thirteen is host address bit ten.
// - single request: pin fourteen drives combined request, default active low.
// - each request output may be driven or open-drain.
// - double request: pin fourteen drives transmit request, default active low.
// - double request: pin fifteen drives receive request, default active low.
// - single request: pin fifteen samples host acknowledge, default active low.
// - read, write and data strobes have programmable polarity, active low at reset.
// - general-purpose mode: each pin direction set from its direction bit.
// - stop state: inputs ignored, outputs tri-stated.
// - wait state, unless stop is also set, leaves pin function, direction and level unchanged.
// - function, style and polarity come from the 16-bit control word.
`default_nettype none
module host_port_pins
  import host_pins_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [CTRL_W-1:0] port_control_reg,
  input  wire logic [NPINS-1:0]  port_direction_reg,
  input  wire logic [NPINS-1:0]  gpio_out,
  input  wire logic              stop_state,
  input  wire logic              wait_state,
  input  wire logic              req_tx,
  input  wire logic              req_rx,
  input  wire logic [NPINS-1:0]  pad_in,
  output logic      [NPINS-1:0]  pad_out,
  output logic      [NPINS-1:0]  pad_oe_n,
  output logic      [NPINS-1:0]  gpio_in,
  output logic                   host_read_access,
  output logic                   host_write_access,
  output logic                   host_chip_select,
  output logic                   host_addr_bit_ten,
  output logic                   host_acknowledge_in
);
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire host_en  = port_control_reg[BIT_HOST_EN];
  wire dbl_strb = port_control_reg[BIT_DBL_STRB];
  wire muxed    = port_control_reg[BIT_MUXED];
  wire dbl_req  = port_control_reg[BIT_DBL_REQ];
  wire req_od   = port_control_reg[BIT_REQ_OD];
  wire strb_pol = port_control_reg[BIT_STRB_POL];
  wire cs_pol   = port_control_reg[BIT_CS_POL];
  wire req_pol  = port_control_reg[BIT_REQ_POL];
  wire ack_pol  = port_control_reg[BIT_ACK_POL];

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] next_out;
  logic [NPINS-1:0] next_oe_n;
  // wait holds every pin as is; stop is handled through next_oe_n
  wire              hold = wait_state & ~stop_state;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      pin_cell u_pin (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .pad_in    (pad_in[g]),
        .hold      (hold),
        .next_out  (next_out[g]),
        .next_oe_n (next_oe_n[g]),
        .pin_sync  (pin_sync[g]),
        .pad_out   (pad_out[g]),
        .pad_oe_n  (pad_oe_n[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // input decode (polarity bit 0 means active low)
  // ----------------------------------------------------------------
  wire strb_a   = pin_sync[0] ^ ~strb_pol;
  wire strb_b   = pin_sync[1] ^ ~strb_pol;
  wire cs_act   = pin_sync[2] ^ ~cs_pol;
  wire ack_act  = pin_sync[4] ^ ~ack_pol;
  wire sel_ok   = muxed | cs_act;
  wire live     = host_en & ~stop_state;
  // single strobe: pin eleven high means read
  wire rd_single = strb_b & pin_sync[0];
  wire wr_single = strb_b & ~pin_sync[0];
  wire next_rd   = live & sel_ok & (dbl_strb ? strb_a : rd_single);
  wire next_wr   = live & sel_ok & (dbl_strb ? strb_b : wr_single);
  wire next_cs   = live & ~muxed & cs_act;
  wire next_a10  = live & muxed & pin_sync[2];
  wire next_ack  = live & ~dbl_req & ack_act;
  // gpio inputs read as zero while stopped: ignored inputs
  wire [NPINS-1:0] next_gin = (host_en | stop_state) ? '0 : pin_sync;

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  wire req14_act = dbl_req ? req_tx : (req_tx | req_rx);
  wire lvl14     = req14_act ^ ~req_pol;
  wire lvl15     = req_rx ^ ~req_pol;
  // open drain pulls only toward the low level, whatever the request polarity, else floats
  wire oe14_n    = req_od ? lvl14 : 1'b0;
  wire oe15_n    = req_od ? lvl15 : 1'b0;

  always_comb begin
    next_out  = gpio_out;
    next_oe_n = ~port_direction_reg;
    if (host_en) begin
      next_out  = {lvl15, lvl14, 3'b000};
      next_oe_n = {dbl_req ? oe15_n : 1'b1, oe14_n, 3'b111};
    end
    if (stop_state) begin
      next_oe_n = '1;
    end
  end

  // ----------------------------------------------------------------
  // registered host-side results
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_read_access    <= 1'b0;
      host_write_access   <= 1'b0;
      host_chip_select    <= 1'b0;
      host_addr_bit_ten   <= 1'b0;
      host_acknowledge_in <= 1'b0;
      gpio_in             <= '0;
    end else if (!hold) begin
      host_read_access    <= next_rd;
      host_write_access   <= next_wr;
      host_chip_select    <= next_cs;
      host_addr_bit_ten   <= next_a10;
      host_acknowledge_in <= next_ack;
      gpio_in             <= next_gin;
    end
  end
endmodule : host_port_pins
`default_nettype wire

// ==== verification/host_port_pins_asserts.sv ====
// assertion checker for the host port pin steering block
`default_nettype none
module host_port_pins_chk
  import host_pins_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic [CTRL_W-1:0] port_control_reg,
  input wire logic [NPINS-1:0]  port_direction_reg,
  input wire logic [NPINS-1:0]  gpio_out,
  input wire logic              stop_state,
  input wire logic              wait_state,
  input wire logic              req_tx,
  input wire logic              req_rx,
  input wire logic [NPINS-1:0]  pad_out,
  input wire logic [NPINS-1:0]  pad_oe_n,
  input wire logic              host_read_access,
  input wire logic              host_write_access
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic [CTRL_W-1:0] c  = port_control_reg;
  // wait and stop freeze or release pins, so request checks skip them
  wire logic              hr = c[0] && !stop_state && !wait_state;
  one_req_a: assert property (hr && !c[3] && !c[4] |=> !pad_oe_n[3] &&
    pad_out[3] == ~$past((req_tx | req_rx) ^ c[7])) else $error("combined request wrong");
  tx_req_a: assert property (hr && c[3] && !c[4] |=> !pad_oe_n[3] &&
    pad_out[3] == ~$past(req_tx ^ c[7])) else $error("tx request wrong");
  rx_req_a: assert property (hr && c[3] && !c[4] |=> !pad_oe_n[4] &&
    pad_out[4] == ~$past(req_rx ^ c[7])) else $error("rx request wrong");
  open_drain_a: assert property (hr && c[4] |=> pad_oe_n[3] == pad_out[3])
    else $error("open-drain drives high");
  stop_tri_a: assert property (stop_state |=> pad_oe_n == 5'h1f)
    else $error("pins driven in stop");
  stop_deaf_a: assert property (stop_state [*4] |->
    !host_read_access && !host_write_access) else $error("strobe seen in stop");
  wait_hold_a: assert property (wait_state && !stop_state |=> $stable({pad_out, pad_oe_n}))
    else $error("pins moved in wait");
  gpio_dir_a: assert property (!c[0] && !stop_state && !wait_state |=>
    pad_oe_n == ~$past(port_direction_reg)) else $error("gpio direction wrong");
  gpio_lvl_a: assert property (!c[0] && !stop_state && !wait_state |=>
    pad_out == $past(gpio_out)) else $error("gpio level wrong");
endmodule : host_port_pins_chk
bind host_port_pins host_port_pins_chk host_port_pins_chk_inst (.clk_sys, .arst_n,
  .port_control_reg, .port_direction_reg, .gpio_out, .stop_state, .wait_state, .req_tx, .req_rx,
  .pad_out, .pad_oe_n, .host_read_access, .host_write_access);
`default_nettype wire

// ==== verification/host_pin_model.sv ====
// host-side pin model: drives strobes, select, address and acknowledge
`default_nettype none
module host_pin_model (
  input  wire logic [4:0] drv_en,
  input  wire logic [4:0] drv_val,
  input  wire logic [4:0] pad_out,
  input  wire logic [4:0] pad_oe_n,
  output logic      [4:0] pad_in
);
  // undriven lines float to the board pull-up, never to the last level
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & drv_en & drv_val)
                | (pad_oe_n & ~drv_en);
endmodule : host_pin_model
`default_nettype wire

// ==== verification/host_port_pins_tb.sv ====
// self-checking bench for the host port pin steering block
`default_nettype none
module host_port_pins_tb
  import host_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 0, arst_n = 0, stop_state = 0, wait_state = 0, req_tx = 0, req_rx = 0;
  logic [15:0] ctrl = CTRL_RESET;
  logic [4:0]  dir = DIR_RESET, gout = 5'h00, en = 5'h00, val = 5'h00;
  logic [4:0]  pad_in, pad_out, pad_oe_n, gpio_in;
  logic        rd, wr, cs, a10, ack;
  int          n_errors = 0, samples_checked = 0;
  host_port_pins host_port_pins_inst (.clk_sys, .arst_n, .port_control_reg(ctrl),
    .port_direction_reg(dir), .gpio_out(gout), .stop_state, .wait_state, .req_tx, .req_rx,
    .pad_in, .pad_out, .pad_oe_n, .gpio_in, .host_read_access(rd), .host_write_access(wr),
    .host_chip_select(cs), .host_addr_bit_ten(a10), .host_acknowledge_in(ack));
  host_pin_model host_pin_model_inst (.drv_en(en), .drv_val(val), .pad_out, .pad_oe_n, .pad_in);
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input logic [4:0] seen, input logic [4:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // four settle cycles cover the two-stage synchroniser plus output register
  task drv(input logic [15:0] c, input logic [4:0] e, input logic [4:0] v, input logic t,
           input logic r);
    @(posedge clk_sys);
    ctrl <= c;
    en <= e;
    val <= v;
    req_tx <= t;
    req_rx <= r;
    repeat (4) @(negedge clk_sys);
  endtask : drv
  task t_single;
    drv(16'h0001, 5'h17, 5'h01, 1'b1, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h15);
    chk(pad_oe_n | pad_out, 5'h17);
    drv(16'h0001, 5'h17, 5'h00, 1'b1, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h0d);
    drv(16'h0001, 5'h17, 5'h04, 1'b1, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h01);
  endtask : t_single
  task t_double;
    drv(16'h002b, 5'h07, 5'h01, 1'b0, 1'b1);
    chk({rd, wr, cs, a10, ack}, 5'h14);
    chk(pad_oe_n, 5'h07);
    chk(pad_out & 5'h18, 5'h08);
    drv(16'h002b, 5'h07, 5'h02, 1'b0, 1'b1);
    chk({rd, wr, cs, a10, ack}, 5'h0c);
  endtask : t_double
  task t_muxed;
    drv(16'h0005, 5'h17, 5'h04, 1'b0, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h0b);
    // active-high chip select and acknowledge
    drv(16'h0141, 5'h17, 5'h15, 1'b0, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h15);
    drv(16'h0141, 5'h17, 5'h11, 1'b0, 1'b0);
    chk({rd, wr, cs, a10, ack}, 5'h01);
  endtask : t_muxed
  task t_od;
    drv(16'h0011, 5'h17, 5'h01, 1'b0, 1'b0);
    chk(pad_oe_n & pad_in & 5'h08, 5'h08);
    drv(16'h0011, 5'h17, 5'h01, 1'b1, 1'b0);
    chk(pad_oe_n & 5'h08, 5'h00);
    drv(16'h0091, 5'h17, 5'h01, 1'b1, 1'b0);
    chk(pad_oe_n & 5'h08, 5'h08);
  endtask : t_od
  task t_gpio;
    @(posedge clk_sys);
    dir <= 5'h0a;
    gout <= 5'h1f;
    drv(16'h0000, 5'h15, 5'h10, 1'b0, 1'b0);
    chk(pad_oe_n, 5'h15);
    chk(gpio_in, 5'h1a);
    @(posedge clk_sys);
    wait_state <= 1'b1;
    gout <= 5'h00;
    repeat (2) @(negedge clk_sys);
    chk(pad_out & 5'h0a, 5'h0a);
    @(posedge clk_sys);
    stop_state <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(pad_oe_n, 5'h1f);
    chk(gpio_in, 5'h00);
  endtask : t_gpio
  task results;
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_single;
    t_double;
    t_muxed;
    t_od;
    t_gpio;
    results;
  end
  initial begin
    repeat (400) @(posedge clk_sys);
    n_errors++;
    results;
  end
endmodule : host_port_pins_tb
`default_nettype wire
